// [setpoint_seq_defines.vh]
`ifndef SETPOINT_SEQ_DEFINES_VH
`define SETPOINT_SEQ_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_AMPL 8'h08
`define A_OFFS 8'h0C
`define A_T1 8'h10
`define A_T2 8'h14
`define A_T3 8'h18
`define A_T4 8'h1C
`define A_CYC 8'h20
`define A_SEQ 8'h24
`define A_SV 8'h28
`define A_SI 8'h2C
`define A_SP 8'h30
`define A_PIDX 8'h34
`define A_PAC 8'h38
`define A_PDC 8'h3C
`define A_PFQ 8'h40
`define A_PANG 8'h44
`define A_PTIME 8'h48
`define A_GEN 8'h4C
// ----------------------------------------
// field positions
// ----------------------------------------
`define C_Q 3
`define C_START 4
`define C_STOP 5
`define C_OFF 6
`define S_ERR 1
`define S_ABORT 2
`define P_ENG 8
// ----------------------------------------
// modes
// ----------------------------------------
`define M_STATIC 3'h0
`define M_RECT 3'h1
`define M_TRAP 3'h2
`define M_ENG 3'h3
`define M_ARB 3'h4
// ----------------------------------------
// limits, scaling and reset values
// ----------------------------------------
`define RATED_V 16'hF000
`define RATED_I 16'hF000
`define TIME_MIN 32'h00000001
`define TIME_MAX 32'h15752A00
`define FREQ_MAX 14'h2710
`define ANG_MAX 9'h167
`define CYC_MAX 10'h3E7
`define NPTS 7'h63
`define NENG 3'h5
`define SLOPE_DF_K 17'h186A0
`define SLOPE_T_K 7'h5D
`define PHASE_PER_HZ 19'h68DB9
`define PHASE_PER_DEG 24'hB60B61
`define PT_TIME_RST 32'h0000000A
`define ENG_V0 32'h6000C000
`define ENG_V1 32'h60006000
`define ENG_V2 32'h80006000
`define ENG_V3 32'h80008000
`define ENG_V4 32'hC0008000
`define ENG_T0 32'h00000032
`define ENG_T1 32'h000000C8
`define ENG_T2 32'h00000064
`define ENG_T3 32'h00002710
`define ENG_T4 32'h000003E8
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define TICK_PERIOD_NS 100000
`define CLOCK_NS 10
`endif

// [setpoint_waveform_sequencer.v]
// Behaviour
// [RQ1] rectangle: offset+amplitude for t1, offset for t2, repeating
// [RQ2] rectangle/trapezoid start only if amplitude+offset within rated value
// [RQ3] trapezoid ramps offset to top over t1, top to offset over t3
// [RQ4] trapezoid holds top for t2, base for t4, then repeats
// [RQ5] trapezoid drives voltage or current as selected
// [RQ6] engine-start pulse drives voltage only
// [RQ7] engine-start curve: five linear segments, voltages within 0..rated
// [RQ8] engine-start curve repeats cycle count times; zero means forever
// [RQ9] wait t1 between engine-start repetitions when count is not one
// [RQ10] static voltage before and after run; current and power stay fixed
// [RQ11] engine-start segments preset to defaults
// [RQ12] 99 arbitrary points, each with its own parameters
// [RQ13] arbitrary block start..end within 1..99, repeated up to 999 or forever
// [RQ14] whole arbitrary function drives one quantity only
// [RQ15] each point: DC ramp plus sine with swept amplitude and frequency
// [RQ16] both frequencies zero: sine suppressed, DC ramp only
// [RQ17] sine starts at configured angle 0..359 degrees
// [RQ18] AC amplitude within +-50% rated current or 0..50% rated voltage
// [RQ19] reject point whose frequency change per second is below 9.3
// [RQ20] reject point whose amplitude change is too small for its time
// [RQ21] each point has its own duration
// [RQ22] undriven set values stay constant while a function runs
// [RQ23] alarm aborts the function and switches the DC input off
// [RQ24] point expiry advances; after block end restart and count down cycles
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`include "setpoint_seq_defines.vh"
`default_nettype none
module setpoint_waveform_sequencer #(
	parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLOCK_NS
) (
	// clock, reset, enable
	input wire CLOCK_I,
	input wire RESET_N_I,
	input wire CE_I,
	// axi4-lite write
	input wire [7:0] AXI_AWADDR_I,
	input wire AXI_AWVALID_I,
	output wire AXI_AWREADY_O,
	input wire [31:0] AXI_WDATA_I,
	input wire [3:0] AXI_WSTRB_I,
	input wire AXI_WVALID_I,
	output wire AXI_WREADY_O,
	output reg [1:0] AXI_BRESP_O,
	output reg AXI_BVALID_O,
	input wire AXI_BREADY_I,
	// axi4-lite read
	input wire [7:0] AXI_ARADDR_I,
	input wire AXI_ARVALID_I,
	output wire AXI_ARREADY_O,
	output reg [31:0] AXI_RDATA_O,
	output reg [1:0] AXI_RRESP_O,
	output reg AXI_RVALID_O,
	input wire AXI_RREADY_I,
	// load side
	input wire ALARM_I,
	output reg [15:0] SET_VOLTAGE_O,
	output reg [15:0] SET_CURRENT_O,
	output reg [15:0] SET_POWER_O,
	output reg DC_INPUT_ON_O,
	output reg FUNC_RUNNING_O
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_LOAD = 4'b0010;
	localparam ST_CALC = 4'b0100;
	localparam ST_RUN = 4'b1000;

	reg [2:0] mode;
	reg quantity;
	reg [15:0] ampl, offs, static_v, static_i, static_p, gen;
	reg [31:0] t1, t2, t3, t4;
	reg [9:0] cycles, cyc_left;
	reg [6:0] seq_first, seq_last, idx;
	reg [8:0] pidx, stg_ang;
	reg [31:0] stg_ac, stg_dc;
	reg [27:0] stg_fq;
	reg [31:0] pt_ac [0:98];
	reg [31:0] pt_dc [0:98];
	reg [31:0] pt_tm [0:98];
	reg [27:0] pt_fq [0:98];
	reg [8:0] pt_ang [0:98];
	reg [31:0] eng_v [0:4];
	reg [31:0] eng_t [0:4];
	reg err, aborted, run_req;
	reg [3:0] state;
	reg [31:0] elapsed, phase, pcnt;
	reg [32:0] rem;
	reg [15:0] frac;
	reg [4:0] dcnt;
	reg aw_full, w_full;
	reg [7:0] waddr;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	integer k;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] s);
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1) begin
				merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
			end
		end
	endfunction

	function tm_ok(input [31:0] t);
		tm_ok = (t >= `TIME_MIN) && (t <= `TIME_MAX);
	endfunction

	function [15:0] rated(input q);
		rated = q ? `RATED_I : `RATED_V;
	endfunction

	function [15:0] absv(input [15:0] a);
		absv = a[15] ? (16'h0000 - a) : a;
	endfunction

	function lvl_ok(input [15:0] ac, input [15:0] dc, input q);
		reg [15:0] m;
		begin
			m = absv(ac);
			lvl_ok = (q || !ac[15]) && (m <= (rated(q) >> 1)) && (dc >= m)
				&& ({1'b0, dc} + {1'b0, m} <= {1'b0, rated(q)});
		end
	endfunction

	function [16:0] lerp(input [16:0] s, input [16:0] e, input [15:0] f);
		reg signed [17:0] d;
		reg signed [35:0] p;
		reg [17:0] r;
		begin
			d = $signed({e[16], e}) - $signed({s[16], s});
			p = d * $signed({2'b00, f});
			r = {s[16], s} + p[33:16];
			lerp = r[16:0];
		end
	endfunction

	function [16:0] sine(input [15:0] p);
		reg [30:0] m;
		reg [15:0] y;
		begin
			m = p[14:0] * (16'h8000 - {1'b0, p[14:0]});
			y = (m[28:13] > 16'h7FFF) ? 16'h7FFF : m[28:13];
			sine = p[15] ? (17'h00000 - {1'b0, y}) : {1'b0, y};
		end
	endfunction

	wire [6:0] pi = (pidx[6:0] < `NPTS) ? pidx[6:0] : 7'h00;
	wire [2:0] pe = (pidx[2:0] < `NENG) ? pidx[2:0] : 3'h0;

	function [31:0] regval(input [7:0] a);
		case (a)
			`A_CTRL: regval = {28'h0, quantity, mode};
			`A_STAT: regval = {17'h0, idx, 4'h0, DC_INPUT_ON_O, aborted, err, FUNC_RUNNING_O};
			`A_AMPL: regval = {16'h0, ampl};
			`A_OFFS: regval = {16'h0, offs};
			`A_T1: regval = t1;
			`A_T2: regval = t2;
			`A_T3: regval = t3;
			`A_T4: regval = t4;
			`A_CYC: regval = {22'h0, cycles};
			`A_SEQ: regval = {17'h0, seq_last, 1'b0, seq_first};
			`A_SV: regval = {16'h0, static_v};
			`A_SI: regval = {16'h0, static_i};
			`A_SP: regval = {16'h0, static_p};
			`A_PIDX: regval = {23'h0, pidx};
			`A_PAC: regval = pidx[`P_ENG] ? 32'h0 : pt_ac[pi];
			`A_PDC: regval = pidx[`P_ENG] ? eng_v[pe] : pt_dc[pi];
			`A_PFQ: regval = pidx[`P_ENG] ? 32'h0 : {4'h0, pt_fq[pi]};
			`A_PANG: regval = pidx[`P_ENG] ? 32'h0 : {23'h0, pt_ang[pi]};
			`A_PTIME: regval = pidx[`P_ENG] ? eng_t[pe] : pt_tm[pi];
			`A_GEN: regval = {16'h0, gen};
			default: regval = 32'h0;
		endcase
	endfunction

	function mapped(input [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `A_GEN);
	endfunction

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	assign AXI_AWREADY_O = CE_I && !aw_full;
	assign AXI_WREADY_O = CE_I && !w_full;
	assign AXI_ARREADY_O = CE_I && !AXI_RVALID_O;
	wire do_wr = aw_full && w_full && !AXI_BVALID_O;
	wire [31:0] wv = merge(regval(waddr), wdata_q, wstrb_q);

	// staged point checks, committed by the time write
	wire [15:0] acs = stg_ac[15:0];
	wire [15:0] ace = stg_ac[31:16];
	wire [13:0] fs = stg_fq[13:0];
	wire [13:0] fe = stg_fq[27:14];
	wire [13:0] df = (fe > fs) ? fe - fs : fs - fe;
	wire [16:0] dac_s = {ace[15], ace} - {acs[15], acs};
	wire [16:0] dac = dac_s[16] ? 17'h00000 - dac_s : dac_s;
	wire slope_ok = (fs == fe) || ({26'h0, df} * `SLOPE_DF_K >= {8'h0, wv} * `SLOPE_T_K); // [RQ19]
	wire amp_ok = (acs == ace) || ({dac, 16'h0000} >= {1'b0, wv}); // [RQ20]
	wire arb_ok = (pidx[6:0] < `NPTS) && lvl_ok(acs, stg_dc[15:0], quantity) // [RQ18]
		&& lvl_ok(ace, stg_dc[31:16], quantity) && (fs <= `FREQ_MAX) // [RQ15]
		&& (fe <= `FREQ_MAX) && (stg_ang <= `ANG_MAX) && tm_ok(wv) // [RQ17] [RQ21]
		&& slope_ok && amp_ok;
	wire eng_ok = (pidx[2:0] < `NENG) && (pidx[7:3] == 5'h0) && tm_ok(wv) // [RQ7]
		&& (stg_dc[15:0] <= `RATED_V) && (stg_dc[31:16] <= `RATED_V);
	wire commit = do_wr && (waddr == `A_PTIME);
	wire pt_ok = pidx[`P_ENG] ? eng_ok : arb_ok;
	wire wr_bad = !mapped(waddr) || (commit && !pt_ok);
	wire wr_ctrl = do_wr && (waddr == `A_CTRL);
	wire wr_stop = wr_ctrl && wv[`C_STOP];
	wire wr_off = wr_ctrl && wv[`C_OFF];

	wire running = FUNC_RUNNING_O;
	wire [15:0] top = ampl + offs;
	wire trap_ok = ({1'b0, ampl} + {1'b0, offs} <= {1'b0, rated(quantity)}) // [RQ2]
		&& tm_ok(t1) && tm_ok(t2);
	reg start_ok;
	always @* begin
		case (mode)
			`M_RECT: start_ok = trap_ok; // [RQ1]
			`M_TRAP: start_ok = trap_ok && tm_ok(t3) && tm_ok(t4); // [RQ3] [RQ4]
			`M_ENG: start_ok = (cycles <= `CYC_MAX) && (cycles == 10'h1 || tm_ok(t1)); // [RQ9]
			`M_ARB: start_ok = (seq_first != 7'h0) && (seq_first <= seq_last) // [RQ13]
				&& (seq_last <= `NPTS) && (cycles <= `CYC_MAX);
			default: start_ok = 1'b0;
		endcase
	end
	wire go = run_req && start_ok && !ALARM_I && (state == ST_IDLE);
	wire start_bad = run_req && !go;

	always @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			waddr <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			AXI_BVALID_O <= 1'b0;
			AXI_BRESP_O <= `RESP_OK;
			AXI_RVALID_O <= 1'b0;
			AXI_RRESP_O <= `RESP_OK;
			AXI_RDATA_O <= 32'h0;
		end else if (CE_I) begin
			if (AXI_AWVALID_I && !aw_full) begin
				aw_full <= 1'b1;
				waddr <= AXI_AWADDR_I;
			end
			if (AXI_WVALID_I && !w_full) begin
				w_full <= 1'b1;
				wdata_q <= AXI_WDATA_I;
				wstrb_q <= AXI_WSTRB_I;
			end
			if (do_wr) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				AXI_BVALID_O <= 1'b1;
				AXI_BRESP_O <= wr_bad ? `RESP_ERR : `RESP_OK;
			end else if (AXI_BREADY_I) begin
				AXI_BVALID_O <= 1'b0;
			end
			if (AXI_ARVALID_I && !AXI_RVALID_O) begin
				AXI_RVALID_O <= 1'b1;
				AXI_RDATA_O <= regval(AXI_ARADDR_I);
				AXI_RRESP_O <= mapped(AXI_ARADDR_I) ? `RESP_OK : `RESP_ERR;
			end else if (AXI_RREADY_I) begin
				AXI_RVALID_O <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// configuration registers and point memory
	// ----------------------------------------
	always @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mode <= `M_STATIC;
			quantity <= 1'b0;
			ampl <= 16'h0000;
			offs <= 16'h0000;
			t1 <= `TIME_MIN;
			t2 <= `TIME_MIN;
			t3 <= `TIME_MIN;
			t4 <= `TIME_MIN;
			cycles <= 10'h001;
			seq_first <= 7'h01;
			seq_last <= 7'h01;
			static_v <= 16'h0000;
			static_i <= 16'h0000;
			static_p <= 16'h0000;
			pidx <= 9'h000;
			stg_ac <= 32'h0;
			stg_dc <= 32'h0;
			stg_fq <= 28'h0;
			stg_ang <= 9'h000;
			err <= 1'b0;
			aborted <= 1'b0;
			run_req <= 1'b0;
			for (k = 0; k < 99; k = k + 1) begin
				pt_ac[k] <= 32'h0;
				pt_dc[k] <= 32'h0;
				pt_fq[k] <= 28'h0;
				pt_ang[k] <= 9'h000;
				pt_tm[k] <= `PT_TIME_RST;
			end
			eng_v[0] <= `ENG_V0; // [RQ11]
			eng_v[1] <= `ENG_V1;
			eng_v[2] <= `ENG_V2;
			eng_v[3] <= `ENG_V3;
			eng_v[4] <= `ENG_V4;
			eng_t[0] <= `ENG_T0;
			eng_t[1] <= `ENG_T1;
			eng_t[2] <= `ENG_T2;
			eng_t[3] <= `ENG_T3;
			eng_t[4] <= `ENG_T4;
		end else if (CE_I) begin
			run_req <= wr_ctrl && wv[`C_START];
			// set wins over a simultaneous clear
			err <= (err && !(do_wr && waddr == `A_STAT && wv[`S_ERR]))
				|| start_bad || (commit && !pt_ok);
			aborted <= (aborted && !(do_wr && waddr == `A_STAT && wv[`S_ABORT]))
				|| (ALARM_I && running);
			if (do_wr) begin
				case (waddr)
					`A_CTRL: begin
						if (!running) begin
							mode <= wv[2:0];
							quantity <= wv[`C_Q]; // [RQ5] [RQ14]
						end
					end
					`A_AMPL: ampl <= wv[15:0];
					`A_OFFS: offs <= wv[15:0];
					`A_T1: t1 <= wv;
					`A_T2: t2 <= wv;
					`A_T3: t3 <= wv;
					`A_T4: t4 <= wv;
					`A_CYC: cycles <= wv[9:0];
					`A_SEQ: begin
						seq_first <= wv[6:0];
						seq_last <= wv[14:8];
					end
					`A_SV: static_v <= wv[15:0];
					`A_SI: static_i <= wv[15:0];
					`A_SP: static_p <= wv[15:0];
					`A_PIDX: pidx <= wv[8:0];
					`A_PAC: stg_ac <= wv;
					`A_PDC: stg_dc <= wv;
					`A_PFQ: stg_fq <= wv[27:0];
					`A_PANG: stg_ang <= wv[8:0];
					`A_PTIME: begin
						if (pt_ok && pidx[`P_ENG]) begin
							eng_v[pidx[2:0]] <= stg_dc;
							eng_t[pidx[2:0]] <= wv;
						end else if (pt_ok) begin // [RQ12]
							pt_ac[pidx[6:0]] <= stg_ac;
							pt_dc[pidx[6:0]] <= stg_dc;
							pt_fq[pidx[6:0]] <= stg_fq;
							pt_ang[pidx[6:0]] <= stg_ang;
							pt_tm[pidx[6:0]] <= wv;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// segment source per mode
	// ----------------------------------------
	wire [2:0] ie = (idx < 7'h05) ? idx[2:0] : 3'h0;
	wire [6:0] ia = (idx < `NPTS) ? idx : 7'h00;
	reg [15:0] seg_s, seg_e, seg_acs, seg_ace;
	reg [31:0] seg_t;
	reg [13:0] seg_fs, seg_fe;
	reg [8:0] seg_ang;
	reg [6:0] first_idx, last_idx;
	always @* begin
		seg_s = offs;
		seg_e = offs;
		seg_t = t2;
		seg_acs = 16'h0000;
		seg_ace = 16'h0000;
		seg_fs = 14'h0000;
		seg_fe = 14'h0000;
		seg_ang = 9'h000;
		first_idx = 7'h00;
		last_idx = 7'h00;
		case (mode)
			`M_RECT: begin
				last_idx = 7'h01;
				if (idx == 7'h00) begin // [RQ1]
					seg_s = top;
					seg_e = top;
					seg_t = t1;
				end
			end
			`M_TRAP: begin
				last_idx = 7'h03;
				case (idx)
					7'h00: begin // [RQ3]
						seg_e = top;
						seg_t = t1;
					end
					7'h01: begin // [RQ4]
						seg_s = top;
						seg_e = top;
					end
					7'h02: begin // [RQ3]
						seg_s = top;
						seg_t = t3;
					end
					default: seg_t = t4; // [RQ4]
				endcase
			end
			`M_ENG: begin
				last_idx = 7'h04;
				if (idx == 7'h05) begin // [RQ9]
					seg_s = static_v;
					seg_e = static_v;
					seg_t = t1;
				end else begin // [RQ7]
					seg_s = eng_v[ie][15:0];
					seg_e = eng_v[ie][31:16];
					seg_t = eng_t[ie];
				end
			end
			`M_ARB: begin // [RQ13] [RQ15]
				first_idx = seq_first - 7'h01;
				last_idx = seq_last - 7'h01;
				seg_s = pt_dc[ia][15:0];
				seg_e = pt_dc[ia][31:16];
				seg_acs = pt_ac[ia][15:0];
				seg_ace = pt_ac[ia][31:16];
				seg_fs = pt_fq[ia][13:0];
				seg_fe = pt_fq[ia][27:14];
				seg_ang = pt_ang[ia];
				seg_t = pt_tm[ia]; // [RQ21]
			end
			default: ;
		endcase
	end

	// ----------------------------------------
	// value computation
	// ----------------------------------------
	wire q_eff = (mode == `M_ENG) ? 1'b0 : quantity; // [RQ6]
	wire sine_en = (mode == `M_ARB) && (seg_fs != 14'h0 || seg_fe != 14'h0); // [RQ16]
	wire [16:0] dcv = lerp({1'b0, seg_s}, {1'b0, seg_e}, frac); // [RQ15]
	wire [16:0] acv = lerp({seg_acs[15], seg_acs}, {seg_ace[15], seg_ace}, frac);
	wire [16:0] fv = lerp({3'h0, seg_fs}, {3'h0, seg_fe}, frac);
	wire signed [33:0] acp = $signed(acv) * $signed(sine(phase[31:16]));
	wire [17:0] sum = {dcv[16], dcv} + (sine_en ? {acp[31], acp[31:15]} : 18'h00000);
	wire [32:0] pstep = fv[13:0] * `PHASE_PER_HZ;
	wire [32:0] pinit = seg_ang * `PHASE_PER_DEG; // [RQ17]
	wire [15:0] clamped = sum[17] ? 16'h0000 :
		(sum[16:0] > {1'b0, rated(q_eff)}) ? rated(q_eff) : sum[15:0];
	wire tick = (pcnt == TICK_CYCLES - 1);
	wire last_run = (mode == `M_ENG || mode == `M_ARB) && (cycles != 10'h0)
		&& (cyc_left <= 10'h001);
	wire [32:0] rem2 = {rem[31:0], 1'b0};

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state <= ST_IDLE;
			idx <= 7'h00;
			elapsed <= 32'h0;
			phase <= 32'h0;
			pcnt <= 32'h0;
			rem <= 33'h0;
			frac <= 16'h0000;
			dcnt <= 5'h00;
			cyc_left <= 10'h000;
			gen <= 16'h0000;
			FUNC_RUNNING_O <= 1'b0;
			DC_INPUT_ON_O <= 1'b0;
			SET_VOLTAGE_O <= 16'h0000;
			SET_CURRENT_O <= 16'h0000;
			SET_POWER_O <= 16'h0000;
		end else if (CE_I) begin
			pcnt <= (tick || go) ? 32'h0 : pcnt + 32'h1;
			SET_VOLTAGE_O <= (running && !q_eff) ? gen : static_v; // [RQ10] [RQ22]
			SET_CURRENT_O <= (running && q_eff) ? gen : static_i; // [RQ22]
			SET_POWER_O <= static_p;
			if (ALARM_I || wr_off) begin // [RQ23]
				DC_INPUT_ON_O <= 1'b0;
			end else if (go) begin
				DC_INPUT_ON_O <= 1'b1;
			end
			if (ALARM_I || wr_stop || wr_off) begin // [RQ23]
				state <= ST_IDLE;
				FUNC_RUNNING_O <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						if (go) begin
							idx <= first_idx;
							cyc_left <= cycles; // [RQ8]
							FUNC_RUNNING_O <= 1'b1;
							state <= ST_LOAD;
						end
					end
					ST_LOAD: begin
						elapsed <= 32'h0;
						phase <= pinit[31:0];
						rem <= 33'h0;
						frac <= 16'h0000;
						dcnt <= 5'h10;
						state <= ST_CALC;
					end
					ST_CALC: begin
						if (dcnt != 5'h00) begin
							dcnt <= dcnt - 5'h01;
							if (rem2 >= {1'b0, seg_t}) begin
								rem <= rem2 - {1'b0, seg_t};
								frac <= {frac[14:0], 1'b1};
							end else begin
								rem <= rem2;
								frac <= {frac[14:0], 1'b0};
							end
						end else begin
							gen <= clamped; // [RQ7] [RQ18]
							phase <= phase + pstep[31:0];
							state <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (tick && (elapsed + 32'h1 >= seg_t)) begin // [RQ24]
							state <= ST_LOAD;
							if (mode == `M_ENG && idx == 7'h05) begin
								idx <= first_idx;
							end else if (idx == last_idx && last_run) begin
								FUNC_RUNNING_O <= 1'b0;
								state <= ST_IDLE;
							end else if (idx == last_idx) begin // [RQ8] [RQ13]
								if (cycles != 10'h0) begin
									cyc_left <= cyc_left - 10'h001;
								end
								idx <= (mode == `M_ENG) ? 7'h05 : first_idx; // [RQ9]
							end else begin
								idx <= idx + 7'h01;
							end
						end else if (tick) begin
							elapsed <= elapsed + 32'h1;
							rem <= {1'b0, elapsed + 32'h1};
							frac <= 16'h0000;
							dcnt <= 5'h10;
							state <= ST_CALC;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [sws_chk.sv]
`include "setpoint_seq_defines.vh"
`default_nettype none
module sws_chk (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic ALARM_I,
	input wire logic AXI_AWVALID_I,
	input wire logic AXI_AWREADY_O,
	input wire logic AXI_WVALID_I,
	input wire logic AXI_WREADY_O,
	input wire logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	input wire logic [1:0] AXI_BRESP_O,
	input wire logic AXI_ARVALID_I,
	input wire logic AXI_ARREADY_O,
	input wire logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	input wire logic [31:0] AXI_RDATA_O,
	input wire logic [15:0] SET_VOLTAGE_O,
	input wire logic [15:0] SET_POWER_O,
	input wire logic DC_INPUT_ON_O,
	input wire logic FUNC_RUNNING_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESET_N_I);
	property p_alarm;
		ALARM_I |-> ##[1:2] !DC_INPUT_ON_O && !FUNC_RUNNING_O;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm left run on");
	property p_rundc;
		FUNC_RUNNING_O |-> DC_INPUT_ON_O;
	endproperty
	a_rundc: assert property (p_rundc) else $error("run without dc input");
	property p_pwr;
		FUNC_RUNNING_O && $past(FUNC_RUNNING_O) |-> $stable(SET_POWER_O);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power moved in run");
	property p_vmax;
		SET_VOLTAGE_O <= `RATED_V;
	endproperty
	a_vmax: assert property (p_vmax) else $error("voltage above rated");
	property p_bhold;
		AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O && $stable(AXI_BRESP_O);
	endproperty
	a_bhold: assert property (p_bhold) else $error("b response dropped");
	property p_rhold;
		AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O && $stable(AXI_RDATA_O);
	endproperty
	a_rhold: assert property (p_rhold) else $error("r response dropped");
	property p_arblk;
		AXI_RVALID_O |-> !AXI_ARREADY_O;
	endproperty
	a_arblk: assert property (p_arblk) else $error("ar ready during r");
	property p_rans;
		AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O;
	endproperty
	a_rans: assert property (p_rans) else $error("late read answer");
	property p_bans;
		AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O && !AXI_BVALID_O
			|-> ##2 AXI_BVALID_O;
	endproperty
	a_bans: assert property (p_bans) else $error("late write answer");
	cover property ($rose(FUNC_RUNNING_O));
	cover property (FUNC_RUNNING_O && ALARM_I);
	cover property (AXI_BVALID_O && AXI_BRESP_O == 2'h2);
endmodule
bind setpoint_waveform_sequencer sws_chk i_chk (.*);
`default_nettype wire

// [dc_source_model.sv]
`default_nettype none
module dc_source_model #(
	parameter int DLY = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trip,
	input wire logic dc_on,
	output var logic alarm
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	// trip raises alarm after a delay while dc_on is set
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n <= 0;
			alarm <= 1'h0;
		end else begin
			n <= (trip && dc_on) ? n + 1 : 0;
			alarm <= trip && (alarm || n >= DLY);
		end
	end
endmodule
`default_nettype wire

// [setpoint_waveform_sequencer_tb.sv]
`include "setpoint_seq_defines.vh"
`default_nettype none
module setpoint_waveform_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst_n = 1'h0, trip = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	wire logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, alarm, dc_on, run;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [15:0] sv, si, sp;
	integer mismatches = 0, total_checks = 0, cycles = 0, n, hi, c;
	always #5 clk = ~clk;
	setpoint_waveform_sequencer #(.TICK_CYCLES(10)) i_dut (
		.CLOCK_I(clk), .RESET_N_I(rst_n), .CE_I(1'h1),
		.AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(aw_rdy),
		.AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(w_rdy),
		.AXI_BRESP_O(bresp), .AXI_BVALID_O(b_vld), .AXI_BREADY_I(bready),
		.AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(ar_rdy),
		.AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(r_vld), .AXI_RREADY_I(rready),
		.ALARM_I(alarm), .SET_VOLTAGE_O(sv), .SET_CURRENT_O(si), .SET_POWER_O(sp),
		.DC_INPUT_ON_O(dc_on), .FUNC_RUNNING_O(run)
	);
	dc_source_model i_src (.clk(clk), .rst_n(rst_n), .trip(trip), .dc_on(dc_on), .alarm(alarm));
	task test_done;
		begin
			$display("checks %0d mismatches %0d", total_checks, mismatches);
			if (mismatches == 0 && total_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches = mismatches + 1;
			test_done;
		end
	end
	task check(input [31:0] seen, input [31:0] exp, input string what);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		logic at, wt;
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			at = 1'h0;
			wt = 1'h0;
			while (!(at && wt)) begin
				@(negedge clk);
				at = at || aw_rdy;
				wt = wt || w_rdy;
				@(posedge clk);
				if (at) awvalid <= 1'h0;
				if (wt) wvalid <= 1'h0;
			end
			do @(negedge clk); while (!b_vld);
			check(bresp, er, "bresp");
			@(posedge clk);
			bready <= 1'h0;
			@(posedge clk);
		end
	endtask
	task rdc(input [7:0] a, input [31:0] m, input [31:0] exp, input [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			do @(negedge clk); while (!ar_rdy);
			@(posedge clk);
			arvalid <= 1'h0;
			do @(negedge clk); while (!r_vld);
			check(rdata & m, exp, "rdata");
			check(rresp, er, "rresp");
			@(posedge clk);
			rready <= 1'h0;
			@(posedge clk);
		end
	endtask
	task wait_v(input bit cur, input [15:0] e);
		begin
			n = 0;
			while ((cur ? si : sv) !== e && n < 400) begin
				@(negedge clk);
				n = n + 1;
			end
			check(cur ? si : sv, e, "set value");
		end
	endtask
	task dwell(input [15:0] e);
		begin
			n = 0;
			while (sv === e && n < 3000) begin
				@(negedge clk);
				n = n + 1;
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		check({dc_on, run, sv, si}, 32'h0, "reset");
		rdc(`A_STAT, 32'hF, 32'h0, `RESP_OK);
		rdc(8'h50, 32'hFFFFFFFF, 32'h0, `RESP_ERR);
		$display("test reset done");
		// ----------------------------------------
		// static values, rejected start
		// ----------------------------------------
		wr(`A_SV, 32'h1000, `RESP_OK);
		wr(`A_SI, 32'h2000, `RESP_OK);
		wr(`A_SP, 32'h3000, `RESP_OK);
		check({sp, sv}, 32'h30001000, "static");
		wr(`A_AMPL, 32'h8000, `RESP_OK);
		wr(`A_OFFS, 32'h7001, `RESP_OK);
		wr(`A_CTRL, 32'h11, `RESP_OK);
		rdc(`A_STAT, 32'hF, 32'h2, `RESP_OK);
		wr(`A_STAT, 32'h2, `RESP_OK);
		$display("test limits done");
		// ----------------------------------------
		// rectangle on voltage, alarm abort
		// ----------------------------------------
		wr(`A_AMPL, 32'h100, `RESP_OK);
		wr(`A_OFFS, 32'h200, `RESP_OK);
		wr(`A_T1, 32'h3, `RESP_OK);
		wr(`A_T2, 32'h4, `RESP_OK);
		wr(`A_CTRL, 32'h11, `RESP_OK);
		wait_v(0, 16'h0300);
		dwell(16'h0300);
		hi = n;
		check(sv, 16'h0200, "rect low");
		dwell(16'h0200);
		check(sv, 16'h0300, "rect high");
		check(hi >= 30 && hi < n, 1'h1, "rect times");
		check({run, si}, 32'h12000, "i held");
		trip <= 1'h1;
		repeat (8) @(posedge clk);
		trip <= 1'h0;
		check({dc_on, run}, 2'h0, "alarm");
		rdc(`A_STAT, 32'hF, 32'h4, `RESP_OK);
		wr(`A_STAT, 32'h4, `RESP_OK);
		$display("test rectangle done");
		// ----------------------------------------
		// trapezoid on current, stop keeps input on
		// ----------------------------------------
		wr(`A_CTRL, 32'h1A, `RESP_OK);
		wait_v(1, 16'h0300);
		check(sv, 16'h1000, "v held");
		wr(`A_CTRL, 32'h20, `RESP_OK);
		repeat (4) @(posedge clk);
		check({dc_on, run, si}, 32'h22000, "stopped");
		wr(`A_CTRL, 32'h40, `RESP_OK);
		check(dc_on, 1'h0, "input off");
		$display("test trapezoid done");
		// ----------------------------------------
		// point checks and engine defaults
		// ----------------------------------------
		wr(`A_PIDX, 32'h0, `RESP_OK);
		wr(`A_PFQ, 32'h2C001, `RESP_OK);
		wr(`A_PTIME, 32'hC350, `RESP_ERR);
		wr(`A_PTIME, 32'h2710, `RESP_OK);
		wr(`A_PFQ, 32'h0, `RESP_OK);
		wr(`A_PDC, 32'h00100010, `RESP_OK);
		wr(`A_PAC, 32'h00020001, `RESP_OK);
		wr(`A_PTIME, 32'h20000, `RESP_ERR);
		wr(`A_STAT, 32'h2, `RESP_OK);
		wr(`A_PIDX, 32'h100, `RESP_OK);
		rdc(`A_PDC, 32'hFFFFFFFF, `ENG_V0, `RESP_OK);
		rdc(`A_PTIME, 32'hFFFFFFFF, `ENG_T0, `RESP_OK);
		wr(`A_PIDX, 32'h104, `RESP_OK);
		rdc(`A_PDC, 32'hFFFFFFFF, `ENG_V4, `RESP_OK);
		$display("test points done");
		// ----------------------------------------
		// arbitrary block, one then two cycles
		// ----------------------------------------
		wr(`A_PIDX, 32'h0, `RESP_OK);
		wr(`A_PAC, 32'h0, `RESP_OK);
		wr(`A_PDC, 32'h05000500, `RESP_OK);
		wr(`A_PTIME, 32'h5, `RESP_OK);
		wr(`A_SEQ, 32'h0101, `RESP_OK);
		for (c = 1; c <= 2; c = c + 1) begin
			wr(`A_CYC, c, `RESP_OK);
			wr(`A_CTRL, 32'h14, `RESP_OK);
			wait_v(0, 16'h0500);
			dwell(16'h0500);
			if (c == 1) hi = n;
			repeat (4) @(posedge clk);
			check({run, sv}, 32'h01000, "block end");
		end
		check(n > hi + hi / 2, 1'h1, "two cycles");
		$display("test arbitrary done");
		test_done;
	end
endmodule
`default_nettype wire
